// file: core/pmrc_delay.sv
// Reset release delay counter
`timescale 1ns/100ps
module pmrc_delay
    import pmrc_pkg::*;
#(
    parameter int CW = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic [CW-1:0] len,
    output logic done
);
    logic [CW-1:0] cnt_q;
    // Counts while not held, saturates at len
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (hold) begin
            cnt_q <= '0;
        end else if (cnt_q != len) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign done = !hold && (cnt_q == len);
endmodule // pmrc_delay

// file: core/pmrc_top.sv
// Power mode control and reset sequencing
// How it works
// - Idle bit write stops CPU clock; peripherals keep clocking.
// - Idle keeps all registers and memory; peripherals keep running.
// - Enabled interrupt in idle clears idle and resumes the CPU.
// - Reset ending idle or stop runs normal reset sequence to vector.
// - Watchdog keeps counting in idle and its reset ends idle.
// - Stop bit write halts internal oscillator, CPU and digital peripherals.
// - Stop ends only by reset; interrupts never wake it.
// - Missing clock detector stays active in stop and may reset.
// - Stop and idle bits always read as zero.
// - Upper six bits are plain flags, zero after reset.
// - Reset halts CPU, resets registers, forces ports, disables interrupts.
// - Reset keeps data memory but reinitialises stack pointer.
// - Port latches go to all ones, open-drain, weak pull-ups on.
// - Power-on and supply monitor resets drive reset pin low.
// - Leaving reset picks internal oscillator, enables watchdog at clock/12.
// - Power-up holds reset until supply good, then release delay.
// - Power-on and supply monitor resets set power-on flag; other resets clear it.
// - Power-on disables supply monitor; other resets keep it.
// - Monitor low supply holds reset and pin; only the short exit delay on recovery.
// - Power-on flag write with monitor off enables it and resets.
// - External pin low forces reset and sets pin reset flag while low.
// - Missing clock timeout resets without driving the reset pin.
`timescale 1ns/100ps
`include "pmrc_defs.svh"
module pmrc_top
    import pmrc_pkg::*;
#(
    parameter int POR_DELAY_CYC = `PMRC_POR_DELAY_CYC,
    parameter int MCD_TIMEOUT_CYC = `PMRC_MCD_TIMEOUT_CYC,
    parameter int EXIT_CYC = `PMRC_RST_EXIT_CYC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire pmrc_sfr_req_t sfr_req,
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic wdt_reset,
    input wire logic sys_clk_level,
    input wire logic supply_good,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe,
    output logic [7:0] sfr_rdata,
    output pmrc_ctl_t ctl,
    output logic [7:0] port_latch_reset,
    output logic weak_pullup_en,
    output logic [15:0] reset_vector,
    output logic wdt_enable,
    output logic [3:0] wdt_div,
    output logic monitor_enabled
);
    ////////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    pmrc_state_t state_q;
    pmrc_state_t state_d;
    logic [5:0] gflags_q;
    logic idle_pend_q;
    logic stop_pend_q;
    logic mon_en_q;
    logic mcd_en_q;
    logic por_flag_q;
    logic pin_flag_q;
    logic mcd_flag_q;
    logic por_phase_q;
    logic [16:0] mcd_cnt_q;
    logic clk_lvl_q;

    // Register decode
    wire pmc_wr = sfr_req.wr && (sfr_req.addr == `PMRC_PMC_ADDR);
    wire rcr_wr = sfr_req.wr && (sfr_req.addr == `PMRC_RCR_ADDR);
    wire pmc_rd = sfr_req.rd && (sfr_req.addr == `PMRC_PMC_ADDR);
    wire rcr_rd = sfr_req.rd && (sfr_req.addr == `PMRC_RCR_ADDR);
    wire mon_kick = rcr_wr && !in_reset && sfr_req.wdata[`PMRC_POR_FLAG_BIT] && !mon_en_q;

    // Reset causes
    // supply monitor holds reset
    wire mon_low = mon_en_q && !supply_good;
    wire pin_low = !rst_pin_in && !rst_pin_oe;
    wire mcd_trip = mcd_en_q && (mcd_cnt_q >= 17'(MCD_TIMEOUT_CYC));
    wire any_cause = mon_low || pin_low || mcd_trip || wdt_reset || mon_kick;

    ////////////////////////////////////////////////////////////////////////////////
    // Release delay: long after power-on, short otherwise
    logic delay_done;
    wire in_reset = (state_q == PMRC_RESET);
    wire delay_hold = !in_reset || any_cause || (por_phase_q && !supply_good);
    wire [16:0] delay_len = por_phase_q ? 17'(POR_DELAY_CYC) : 17'(EXIT_CYC);
    pmrc_delay #(
        .CW(17)
    ) u_delay (
        .mclk(mclk),
        .rst_n(rst_n),
        .hold(delay_hold),
        .len(delay_len),
        .done(delay_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Power mode state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            PMRC_RUN: begin
                if (stop_pend_q && instr_done) begin
                    state_d = PMRC_STOP;
                end else if (idle_pend_q && instr_done) begin
                    state_d = PMRC_IDLE;
                end
            end
            PMRC_IDLE: state_d = irq_pending ? PMRC_RUN : PMRC_IDLE;
            PMRC_STOP: state_d = PMRC_STOP;
            PMRC_RESET: state_d = delay_done ? PMRC_RUN : PMRC_RESET;
            default: state_d = PMRC_RESET;
        endcase
        if (any_cause) begin
            state_d = PMRC_RESET;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= PMRC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power mode control register
    // general flags; select bits latch until the instruction ends
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gflags_q <= '0;
            idle_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end else if (in_reset || any_cause) begin
            gflags_q <= '0;
            idle_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end else if (pmc_wr) begin
            gflags_q <= sfr_req.wdata[7:`PMRC_GF_LSB];
            idle_pend_q <= sfr_req.wdata[`PMRC_IDLE_BIT];
            stop_pend_q <= sfr_req.wdata[`PMRC_STOP_BIT];
        end else if (instr_done) begin
            idle_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset cause flags and enables
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            por_phase_q <= 1'b1;
            mon_en_q <= 1'b0;
            mcd_en_q <= 1'b0;
            por_flag_q <= 1'b0;
            pin_flag_q <= 1'b0;
            mcd_flag_q <= 1'b0;
        end else begin
            if (rcr_wr && !in_reset) begin
                mon_en_q <= mon_en_q | sfr_req.wdata[`PMRC_POR_FLAG_BIT];
                if (mon_en_q && !sfr_req.wdata[`PMRC_POR_FLAG_BIT]) begin
                    mon_en_q <= 1'b0;
                end
                mcd_en_q <= sfr_req.wdata[`PMRC_MCD_FLAG_BIT];
            end
            if (mon_low) begin
                por_phase_q <= 1'b0;
            end
            // power-on and monitor resets set power-on flag, others clear it
            if (any_cause) begin
                por_flag_q <= mon_low;
                pin_flag_q <= pin_low;
                mcd_flag_q <= mcd_trip;
            end else if (in_reset && delay_done) begin
                if (por_phase_q) begin
                    por_flag_q <= 1'b1;
                end
                por_phase_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Missing clock one-shot
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            clk_lvl_q <= 1'b0;
            mcd_cnt_q <= '0;
        end else begin
            clk_lvl_q <= sys_clk_level;
            if (clk_lvl_q != sys_clk_level || in_reset) begin
                mcd_cnt_q <= '0;
            end else if (mcd_cnt_q != 17'h1FFFF) begin
                mcd_cnt_q <= mcd_cnt_q + 17'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data
    // select bits read zero
    wire [7:0] pmc_view = {gflags_q, 2'h0};
    wire [7:0] rcr_view = {5'h00, mcd_flag_q, por_flag_q, pin_flag_q};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= pmc_rd ? pmc_view : (rcr_rd ? rcr_view : 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and reset controls
    // peripherals and watchdog clocked in idle
    assign ctl.periph_clk_en = (state_q == PMRC_RUN) || (state_q == PMRC_IDLE);
    // CPU clock off in idle and stop
    assign ctl.cpu_clk_en = (state_q == PMRC_RUN);
    assign ctl.int_osc_en = (state_q != PMRC_STOP);
    // core reset reloads registers and stack pointer, memory untouched
    assign ctl.core_rst = in_reset;
    assign port_latch_reset = `PMRC_PORT_RESET;
    assign weak_pullup_en = 1'b1;
    assign reset_vector = `PMRC_RESET_VECTOR;
    assign wdt_enable = 1'b1;
    assign wdt_div = 4'(`PMRC_WDT_DIV);
    assign monitor_enabled = mon_en_q;
    // pin low for power-on and monitor resets only
    assign rst_pin_oe = in_reset && (por_phase_q || mon_low || por_flag_q); // Monitor reset holds pin to exit
    assign rst_pin_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_stop_stays;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == PMRC_STOP) && !any_cause |=> (state_q == PMRC_STOP);
    endproperty
    a_stop_stays: assert property (p_stop_stays) else $error("stop left without reset");
    property p_idle_wake;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == PMRC_IDLE) && irq_pending && !any_cause |=> (state_q == PMRC_RUN) && ctl.cpu_clk_en;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("interrupt did not wake idle");
    property p_cause_reset;
        @(posedge mclk) disable iff (!rst_n)
        any_cause |=> in_reset && ctl.core_rst;
    endproperty
    a_cause_reset: assert property (p_cause_reset) else $error("reset cause ignored");
    property p_read_zero;
        @(posedge mclk) disable iff (!rst_n)
        pmc_rd |=> (sfr_rdata[1:0] == 2'h0);
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("select bits read nonzero");
    property p_stop_first;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == PMRC_RUN) && stop_pend_q && idle_pend_q && instr_done && !any_cause |=> (state_q == PMRC_STOP);
    endproperty
    a_stop_first: assert property (p_stop_first) else $error("stop did not win over idle");
    property p_stop_osc;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == PMRC_STOP) |-> !ctl.int_osc_en && !ctl.periph_clk_en;
    endproperty
    a_stop_osc: assert property (p_stop_osc) else $error("clocks alive in stop");
    property p_mon_pin;
        @(posedge mclk) disable iff (!rst_n)
        mon_low |=> rst_pin_oe;
    endproperty
    a_mon_pin: assert property (p_mon_pin) else $error("reset pin not driven on low supply");
    property p_mcd_pin;
        @(posedge mclk) disable iff (!rst_n)
        mcd_trip && !por_phase_q && !mon_low |=> !rst_pin_oe;
    endproperty
    a_mcd_pin: assert property (p_mcd_pin) else $error("pin driven by missing clock reset");
    property p_kick;
        @(posedge mclk) disable iff (!rst_n)
        mon_kick |=> in_reset && mon_en_q;
    endproperty
    a_kick: assert property (p_kick) else $error("monitor enable did not reset");
endmodule // pmrc_top

// file: shared/pmrc_defs.svh
// Offsets, field positions, reset values and timing counts for the power mode and reset control block
`ifndef PMRC_DEFS_SVH
`define PMRC_DEFS_SVH
`define PMRC_PMC_ADDR 8'h87
`define PMRC_RCR_ADDR 8'hEF
`define PMRC_PMC_RESET 8'h00
`define PMRC_IDLE_BIT 0
`define PMRC_STOP_BIT 1
`define PMRC_GF_LSB 2
`define PMRC_PIN_FLAG_BIT 0
`define PMRC_POR_FLAG_BIT 1
`define PMRC_MCD_FLAG_BIT 2
`define PMRC_RESET_VECTOR 16'h0000
`define PMRC_PORT_RESET 8'hFF
`define PMRC_WDT_DIV 12
`define PMRC_CLK_MHZ 50
`define PMRC_POR_DELAY_US 300
`define PMRC_POR_DELAY_CYC (`PMRC_POR_DELAY_US * `PMRC_CLK_MHZ)
`define PMRC_MCD_TIMEOUT_US 100
`define PMRC_MCD_TIMEOUT_CYC (`PMRC_MCD_TIMEOUT_US * `PMRC_CLK_MHZ)
`define PMRC_RST_EXIT_US 5
`define PMRC_RST_EXIT_CYC (`PMRC_RST_EXIT_US * `PMRC_CLK_MHZ)
`endif

// file: shared/pmrc_pkg.sv
// Types of the power mode and reset control block
package pmrc_pkg;
    typedef enum logic [1:0] {
        PMRC_RUN = 2'h0,
        PMRC_IDLE = 2'h1,
        PMRC_STOP = 2'h2,
        PMRC_RESET = 2'h3
    } pmrc_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmrc_sfr_req_t;
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic int_osc_en;
        logic core_rst;
    } pmrc_ctl_t;
endpackage

// file: testbench/pmrc_far_model.sv
// Model of the core-side system clock and the external reset circuitry
`timescale 1ns/100ps
module pmrc_far_model
    import pmrc_pkg::*;
(
    input wire logic mclk,
    input wire logic osc_on,
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic ext_low,
    output logic sys_clk_level,
    output logic rst_pin_in
);
    logic lvl_q = 1'b0;

    ////////////////////////////////////////////////////////////////
    // clock halts with oscillator
    always @(posedge mclk) begin
        if (osc_on) begin
            lvl_q <= ~lvl_q;
        end
    end
    assign sys_clk_level = lvl_q;

    assign rst_pin_in = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule // pmrc_far_model

// file: testbench/pmrc_top_tb_top.sv
// Self-checking testbench of the power mode and reset control block
`timescale 1ns/100ps
`include "pmrc_defs.svh"
module pmrc_top_tb_top
    import pmrc_pkg::*;
;
    logic mclk, rstn, instr_done, irq_pending, wdt_reset, supply_good, ext_low;
    logic sys_clk_level, rst_pin_in, rst_pin_out, rst_pin_oe, weak_pullup_en, wdt_enable, monitor_enabled;
    pmrc_sfr_req_t sfr_req;
    pmrc_ctl_t ctl;
    logic [7:0] sfr_rdata, port_latch_reset;
    logic [15:0] reset_vector;
    logic [3:0] wdt_div;
    int fail_count = 0;
    int n_checks = 0;

    pmrc_top #(.POR_DELAY_CYC(20), .MCD_TIMEOUT_CYC(30), .EXIT_CYC(5)) dut (
        .mclk(mclk), .rstn(rstn), .sfr_req(sfr_req), .instr_done(instr_done), .irq_pending(irq_pending),
        .wdt_reset(wdt_reset), .sys_clk_level(sys_clk_level), .supply_good(supply_good),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sfr_rdata(sfr_rdata),
        .ctl(ctl), .port_latch_reset(port_latch_reset), .weak_pullup_en(weak_pullup_en),
        .reset_vector(reset_vector), .wdt_enable(wdt_enable), .wdt_div(wdt_div),
        .monitor_enabled(monitor_enabled));

    pmrc_far_model far (
        .mclk(mclk), .osc_on(ctl.int_osc_en), .pin_oe(rst_pin_oe), .pin_out(rst_pin_out),
        .ext_low(ext_low), .sys_clk_level(sys_clk_level), .rst_pin_in(rst_pin_in));

    ////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One register access; read data is settled on return
    task automatic special_function_register(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        #1 sfr_req = '0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        special_function_register(1'b0, a, 8'h00);
        chk(name, {8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    task automatic step_done();
        @(posedge mclk);
        #1 instr_done = 1'b1;
        @(posedge mclk);
        #1 instr_done = 1'b0;
    endtask

    // Bounded wait on core reset (0) or cpu clock enable (1)
    task automatic wait_sig(input int w, input logic val, input int lim);
        repeat (lim) begin
            if ((w == 0 ? ctl.core_rst : ctl.cpu_clk_en) === val) break;
            @(posedge mclk);
            #1;
        end
        chk(w == 0 ? "core_rst" : "cpu_clk_en", {15'h0, w == 0 ? ctl.core_rst : ctl.cpu_clk_en}, {15'h0, val});
    endtask

    ////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rstn = 1'b0; sfr_req = '0; instr_done = 1'b0; irq_pending = 1'b0;
        wdt_reset = 1'b0; supply_good = 1'b1; ext_low = 1'b0;
        repeat (8) @(posedge mclk);
        #1 rstn = 1'b1;
        chk("por_pin", {15'h0, rst_pin_oe}, 16'h0001);
        repeat (10) @(posedge mclk);
        #1 chk("por_hold", {15'h0, ctl.core_rst}, 16'h0001);
        wait_sig(0, 1'b0, 100);
        chk("ports", {8'h00, port_latch_reset}, {8'h00, `PMRC_PORT_RESET});
        chk("pullup", {15'h0, weak_pullup_en}, 16'h0001);
        chk("vector", reset_vector, `PMRC_RESET_VECTOR);
        chk("wdt", {11'h0, wdt_enable, wdt_div}, {11'h1, 4'(`PMRC_WDT_DIV)});
        chk("monitor", {15'h0, monitor_enabled}, 16'h0000);
        rd_chk("pmc_reset", `PMRC_PMC_ADDR, `PMRC_PMC_RESET);
        rd_chk("por_flag", `PMRC_RCR_ADDR, 8'h02);
        rd_chk("unmapped", 8'h80, 8'h00);
        special_function_register(1'b1, `PMRC_PMC_ADDR, 8'hFC);
        rd_chk("flags", `PMRC_PMC_ADDR, 8'hFC);
        // Idle, then wake by interrupt
        special_function_register(1'b1, `PMRC_PMC_ADDR, 8'hA5);
        step_done();
        wait_sig(1, 1'b0, 4);
        chk("periph", {15'h0, ctl.periph_clk_en}, 16'h0001);
        rd_chk("idle_keep", `PMRC_PMC_ADDR, 8'hA4);
        irq_pending = 1'b1;
        wait_sig(1, 1'b1, 4);
        irq_pending = 1'b0;
        rd_chk("idle_clr", `PMRC_PMC_ADDR, 8'hA4);
        // Idle ended by watchdog reset
        special_function_register(1'b1, `PMRC_PMC_ADDR, 8'h01);
        step_done();
        wait_sig(1, 1'b0, 4);
        wdt_reset = 1'b1;
        wait_sig(0, 1'b1, 4);
        wdt_reset = 1'b0;
        wait_sig(0, 1'b0, 100);
        rd_chk("after_wdt", `PMRC_PMC_ADDR, 8'h00);
        rd_chk("por_cleared", `PMRC_RCR_ADDR, 8'h00);
        // Stop and idle together, interrupt ignored, pin reset ends it
        special_function_register(1'b1, `PMRC_PMC_ADDR, 8'h03);
        step_done();
        wait_sig(1, 1'b0, 4);
        chk("osc_off", {14'h0, ctl.int_osc_en, ctl.periph_clk_en}, 16'h0000);
        irq_pending = 1'b1;
        repeat (10) @(posedge mclk);
        #1 chk("stop_irq", {15'h0, ctl.cpu_clk_en}, 16'h0000);
        irq_pending = 1'b0;
        ext_low = 1'b1;
        wait_sig(0, 1'b1, 4);
        repeat (10) @(posedge mclk);
        #1 ext_low = 1'b0;
        wait_sig(0, 1'b0, 100);
        rd_chk("pin_flag", `PMRC_RCR_ADDR, 8'h01);
        // Enabling the supply monitor resets once
        special_function_register(1'b1, `PMRC_RCR_ADDR, 8'h02);
        wait_sig(0, 1'b1, 4);
        wait_sig(0, 1'b0, 100);
        chk("mon_on", {15'h0, monitor_enabled}, 16'h0001);
        special_function_register(1'b1, `PMRC_RCR_ADDR, 8'h02);
        repeat (4) @(posedge mclk);
        #1 chk("no_rst", {15'h0, ctl.core_rst}, 16'h0000);
        // Supply drop
        supply_good = 1'b0;
        wait_sig(0, 1'b1, 4);
        chk("pin_drv", {15'h0, rst_pin_oe}, 16'h0001);
        chk("pin_out", {15'h0, rst_pin_out}, 16'h0000);
        repeat (10) @(posedge mclk);
        #1 supply_good = 1'b1;
        chk("pin_hold", {15'h0, rst_pin_oe}, 16'h0001);
        wait_sig(0, 1'b0, 12);
        chk("mon_kept", {15'h0, monitor_enabled}, 16'h0001);
        rd_chk("mon_flag", `PMRC_RCR_ADDR, 8'h02);
        // Missing clock in stop
        special_function_register(1'b1, `PMRC_RCR_ADDR, 8'h06);
        special_function_register(1'b1, `PMRC_PMC_ADDR, 8'h02);
        step_done();
        wait_sig(0, 1'b1, 60);
        chk("mcd_pin", {15'h0, rst_pin_oe}, 16'h0000);
        wait_sig(0, 1'b0, 100);
        rd_chk("mcd_flag", `PMRC_RCR_ADDR, 8'h04);
        tally_and_finish();
    end
endmodule // pmrc_top_tb_top
